// ===== pkg/mon_pkg.sv
`default_nettype none
package mon_pkg;
    // Register read addresses on the host port
    localparam logic [3:0] ADDR_CMD1 = 4'h0;
    localparam logic [3:0] ADDR_CMD2 = 4'h1;
    localparam logic [3:0] ADDR_MODE_DATA = 4'h2;
    localparam logic [3:0] ADDR_RX_FIFO = 4'h4;
    localparam logic [3:0] ADDR_MSG_TYPE = 4'h6;
    localparam logic [3:0] ADDR_BUS_A_WORD = 4'h9;
    localparam logic [3:0] ADDR_BUS_B_WORD = 4'hA;

    // Message-type values
    localparam logic [15:0] MT_RX = 16'h0001;
    localparam logic [15:0] MT_RX_BC = 16'h0080;
    localparam logic [15:0] MT_RTRT = 16'h0004;
    localparam logic [15:0] MT_RTRT_BC = 16'h0100;
    localparam logic [15:0] MT_TX = 16'h0402;
    localparam logic [15:0] MT_MC_LO = 16'h0410;
    localparam logic [15:0] MT_MC_BC = 16'h0400;
    localparam logic [15:0] MT_MC_TX_HI = 16'h2420;
    localparam logic [15:0] MT_MC_RX_HI = 16'h0040;
    localparam logic [15:0] MT_MC_RX_HI_BC = 16'h0800;

    // Command word fields
    localparam int TA_HI = 15;
    localparam int TA_LO = 11;
    localparam int TR_BIT = 10;
    localparam int SA_HI = 9;
    localparam int SA_LO = 5;
    localparam int MC_HI_BIT = 4;
    localparam int WC_HI = 4;
    localparam int MIRROR_LO = 5;
    localparam int MIRROR_HI = 13;
    localparam logic [4:0] BCAST_ADDR = 5'h1F;
    localparam logic [4:0] SA_MODE0 = 5'h00;
    localparam logic [4:0] SA_MODE1 = 5'h1F;

    // Word and receive store sizes
    localparam int WORD_W = 16;
    localparam int FIFO_AW = 5;
    localparam logic [FIFO_AW:0] FIFO_DEPTH = 6'h20;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // Broadcast mode value clears this long after the notification
    localparam int CLK_PERIOD_NS = 10;
    localparam int BCAST_CLR_NS = 550;
    localparam int BCAST_CLR_CYC = (BCAST_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] BCAST_CLR_LOAD = 6'(BCAST_CLR_CYC - 1);

    // Capture sequencer, Gray along idle -> pair wait -> capture
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD2 = 2'b01,
        ST_CAPT = 2'b11
    } seq_t;
endpackage
`default_nettype wire

// ===== rtl/cmd_type_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module cmd_type_decoder (
    input wire logic [15:0] cmdWord, // First command word
    input wire logic rtRtPair, // Second command with transmit bit followed
    output logic [15:0] msgType, // Message-type value
    output logic [5:0] dataCnt, // Data words expected
    output logic [1:0] statusCnt, // Status words expected
    output logic holdForPair, // Receive command, wait for next word
    output logic modeRx, // Data word goes to mode data register
    output logic timedClr // Broadcast value is cleared later
);
    logic bcast;
    logic tx;
    logic isMode;
    logic mcHi;
    logic [15:0] raw;

    // Field split of the command word
    assign bcast = cmdWord[mon_pkg::TA_HI:mon_pkg::TA_LO] == mon_pkg::BCAST_ADDR;
    assign tx = cmdWord[mon_pkg::TR_BIT];
    assign isMode = cmdWord[mon_pkg::SA_HI:mon_pkg::SA_LO] == mon_pkg::SA_MODE0
        || cmdWord[mon_pkg::SA_HI:mon_pkg::SA_LO] == mon_pkg::SA_MODE1;
    assign mcHi = cmdWord[mon_pkg::MC_HI_BIT];

    // Type table; broadcast transmit non-mode is not legal, keep bit 10 only
    always_comb begin
        raw = mon_pkg::MT_MC_BC;
        timedClr = 1'b0;
        if (rtRtPair) begin
            raw = bcast ? mon_pkg::MT_RTRT_BC : mon_pkg::MT_RTRT;
        end else if (!isMode) begin
            if (tx) begin
                raw = bcast ? mon_pkg::MT_MC_BC : mon_pkg::MT_TX;
            end else begin
                raw = bcast ? mon_pkg::MT_RX_BC : mon_pkg::MT_RX;
            end
        end else if (!mcHi) begin
            raw = bcast ? mon_pkg::MT_MC_BC : mon_pkg::MT_MC_LO;
            timedClr = bcast && tx;
        end else if (tx) begin
            raw = bcast ? mon_pkg::MT_MC_BC : mon_pkg::MT_MC_TX_HI;
            timedClr = bcast;
        end else begin
            raw = bcast ? mon_pkg::MT_MC_RX_HI_BC : mon_pkg::MT_MC_RX_HI;
        end
    end

    // Bits 5 and 13 always read alike
    always_comb begin
        msgType = raw;
        msgType[mon_pkg::MIRROR_LO] = raw[mon_pkg::MIRROR_LO] | raw[mon_pkg::MIRROR_HI];
        msgType[mon_pkg::MIRROR_HI] = raw[mon_pkg::MIRROR_LO] | raw[mon_pkg::MIRROR_HI];
    end

    // Word counts: a zero count field means 32 words
    assign dataCnt = isMode ? {5'h00, mcHi}
        : {cmdWord[mon_pkg::WC_HI:0] == 5'h00, cmdWord[mon_pkg::WC_HI:0]};
    assign statusCnt = bcast ? {1'b0, rtRtPair} : (rtRtPair ? 2'h2 : 2'h1);
    assign holdForPair = !isMode && !tx && !rtRtPair;
    assign modeRx = isMode && mcHi && !tx;
endmodule
`default_nettype wire

// ===== rtl/rx_word_mem.sv
`timescale 1ns/1ps
`default_nettype none
module rx_word_mem (
    input wire logic clk, // System clock
    input wire logic wrEn, // Write strobe
    input wire logic [4:0] wrAddr, // Write address
    input wire logic [15:0] wrData, // Write data
    input wire logic [4:0] rdAddr, // Read address
    output logic [15:0] rdData // Registered read data
);
    logic [15:0] mem [0:31]; // Word store, no reset needed

    // Write port and registered read port
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire

// ===== rtl/mil1553_monitor_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module mil1553_monitor_command_decoder (
    input wire logic clk, // System clock, 100 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic wordValidA, // Bus A decoder word strobe
    input wire logic [15:0] wordA, // Bus A word
    input wire logic cmdSyncA, // Bus A word had command sync
    input wire logic wordErrA, // Bus A word failed checks
    input wire logic wordValidB, // Bus B decoder word strobe
    input wire logic [15:0] wordB, // Bus B word
    input wire logic cmdSyncB, // Bus B word had command sync
    input wire logic wordErrB, // Bus B word failed checks
    input wire logic terminal_mode_select, // Mode select pin
    input wire logic controller_mode_select, // Mode select pin
    input wire logic [4:0] own_terminal_address, // Wired terminal address
    input wire logic hostCs_n, // Host chip select, low active
    input wire logic hostStrobe_n, // Host strobe, low active
    input wire logic hostRead, // High for read
    input wire logic [3:0] hostAddr, // Host register address
    output logic [15:0] hostDataOut, // Read data
    output logic hostDataOe, // Drive enable of data pins
    output logic valid_command_notify, // Valid command seen
    output logic bus_a_command_notify, // Valid command came on bus A
    output logic bus_b_command_notify, // Valid command came on bus B
    output logic capture_flag_n, // Low while a message is captured
    output logic rx_fifo_empty, // High when no stored word
    output logic monitor_only_mode, // Monitor without address active
    output logic busDriveAllow, // Transmitters may be enabled
    output logic rtCommandReq // Command for own address, pulse
);
    // State of the block apart from the reset pipe and the word store
    typedef struct packed {
        logic [1:0] modeS1; // Mode pins, first stage
        logic [1:0] modeS2; // Mode pins, second stage
        logic [4:0] rtaS1; // Address pins, first stage
        logic [4:0] rtaS2; // Address pins, second stage
        logic [6:0] hostS1; // Host control, first stage
        logic [6:0] hostS2; // Host control, second stage
        logic rdActPrev; // Read strobe seen last cycle
        logic [3:0] rdAddrHeld; // Address of the running read
        mon_pkg::seq_t state; // Capture sequencer
        logic onB; // Message runs on bus B
        logic [15:0] cmd1; // First command word
        logic [15:0] cmd2; // Second command word
        logic [15:0] modeData; // Received mode data
        logic [15:0] msgType; // Message type
        logic [15:0] busAWord; // Last good word on A
        logic [15:0] busBWord; // Last good word on B
        logic [5:0] wordsLeft; // Data words still due
        logic [1:0] statusLeft; // Status words still due
        logic modeRx; // Next data word is mode data
        logic clrArm; // Timed clear pending
        logic [5:0] clrCnt; // Cycles to timed clear
        logic notify; // Valid command notice
        logic notifyA; // Notice, bus A
        logic notifyB; // Notice, bus B
        logic flagN; // Capture flag, low active
        logic monOnly; // Monitor-only mode
        logic driveAllow; // Bus drive permitted
        logic rtReq; // Own-address command pulse
        logic [15:0] dataOut; // Host read data
        logic dataOe; // Host data drive
        logic [5:0] wrPtr; // Store write pointer
        logic [5:0] rdPtr; // Store read pointer
        logic empty; // Store empty flag
    } state_t;

    state_t r; // Registered state
    state_t n; // Next state
    logic [1:0] rstPipe; // Reset release synchroniser
    logic rstSync; // Released reset, low active

    logic okA; // Good word on A
    logic okB; // Good word on B
    logic selB; // Word source for the sequencer
    logic inOk; // Good word on the followed bus
    logic [15:0] inWord; // That word
    logic inCmd; // That word had command sync
    logic captureOn; // One of the monitor modes
    logic monAssigned; // Monitor with own address
    logic newCmd; // A message starts now
    logic commit; // Message type is settled now
    logic [15:0] decWord; // Word fed to the decoder
    logic decPair; // Paired transfer seen
    logic [15:0] decMsg; // Decoded type
    logic [5:0] decCnt; // Decoded data count
    logic [1:0] decStat; // Decoded status count
    logic decHold; // Receive command, may pair
    logic decModeRx; // Mode data follows
    logic decClr; // Timed clear needed
    logic pushEn; // Store write
    logic full; // Store full
    logic pop; // Store read done
    logic rdAct; // Host read strobe active
    logic [15:0] memRdData; // Head word of the store
    logic [15:0] readMux; // Register selected by address

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync = rstPipe[1];

    // Type lookup for the command under decode
    cmd_type_decoder u_dec (
        .cmdWord(decWord),
        .rtRtPair(decPair),
        .msgType(decMsg),
        .dataCnt(decCnt),
        .statusCnt(decStat),
        .holdForPair(decHold),
        .modeRx(decModeRx),
        .timedClr(decClr)
    );

    // Captured data and status words
    rx_word_mem u_mem (
        .clk(clk),
        .wrEn(pushEn),
        .wrAddr(r.wrPtr[4:0]),
        .wrData(inWord),
        .rdAddr(r.rdPtr[4:0]),
        .rdData(memRdData)
    );

    // Word selection from the two decoders
    always_comb begin
        okA = wordValidA && !wordErrA;
        okB = wordValidB && !wordErrB;
        // Idle follows whichever bus speaks, A wins a tie
        selB = (r.state == mon_pkg::ST_IDLE) ? (!okA && okB) : r.onB;
        inOk = selB ? okB : okA;
        inWord = selB ? wordB : wordA;
        inCmd = selB ? cmdSyncB : cmdSyncA;
        monAssigned = r.modeS2 == 2'b00;
        captureOn = r.monOnly || monAssigned;
        // A command after all status words starts a new message
        newCmd = captureOn && inOk && inCmd
            && (r.state == mon_pkg::ST_IDLE
            || (r.state == mon_pkg::ST_CAPT && r.statusLeft == 2'h0));
        decWord = (r.state == mon_pkg::ST_CMD2) ? r.cmd1 : inWord;
        decPair = r.state == mon_pkg::ST_CMD2 && inCmd && inWord[mon_pkg::TR_BIT];
    end

    // Host register read selection
    always_comb begin
        case (r.hostS2[3:0])
            mon_pkg::ADDR_CMD1: readMux = r.cmd1;
            mon_pkg::ADDR_CMD2: readMux = r.cmd2;
            mon_pkg::ADDR_MODE_DATA: readMux = r.modeData;
            mon_pkg::ADDR_RX_FIFO: readMux = memRdData;
            mon_pkg::ADDR_MSG_TYPE: readMux = r.msgType;
            mon_pkg::ADDR_BUS_A_WORD: readMux = r.busAWord;
            mon_pkg::ADDR_BUS_B_WORD: readMux = r.busBWord;
            default: readMux = mon_pkg::WORD_RESET;
        endcase
    end

    // Next-state logic for the whole block
    always_comb begin
        n = r;
        commit = 1'b0;
        pushEn = 1'b0;
        pop = 1'b0;
        n.rtReq = 1'b0;

        // Pins from outside pass two flops before use
        n.modeS1 = {terminal_mode_select, controller_mode_select};
        n.modeS2 = r.modeS1;
        n.rtaS1 = own_terminal_address;
        n.rtaS2 = r.rtaS1;
        n.hostS1 = {hostCs_n, hostStrobe_n, hostRead, hostAddr};
        n.hostS2 = r.hostS1;

        // Mode: monitor-only keeps the transmitters off while its pins are set
        n.monOnly = r.modeS2 == 2'b11;
        n.driveAllow = monAssigned;

        // Last good word per bus, whatever the sequencer does
        if (okA) begin
            n.busAWord = wordA;
        end
        if (okB) begin
            n.busBWord = wordB;
        end

        // Timed clear of the broadcast mode value
        if (r.clrArm) begin
            if (r.clrCnt == 6'h00) begin
                n.msgType = mon_pkg::WORD_RESET;
                n.clrArm = 1'b0;
            end else begin
                n.clrCnt = r.clrCnt - 6'h01;
            end
        end

        // Capture sequencer
        case (r.state)
            mon_pkg::ST_IDLE, mon_pkg::ST_CAPT: begin
                if (newCmd) begin
                    n.cmd1 = inWord;
                    n.onB = selB;
                    n.flagN = 1'b0;
                    n.notify = 1'b0;
                    n.notifyA = 1'b0;
                    n.notifyB = 1'b0;
                    // Own address goes to the terminal logic as well
                    n.rtReq = monAssigned
                        && inWord[mon_pkg::TA_HI:mon_pkg::TA_LO] == r.rtaS2;
                    if (decHold) begin
                        // Receive command: next word tells pair from data
                        n.state = mon_pkg::ST_CMD2;
                    end else begin
                        commit = 1'b1;
                    end
                end else if (r.state == mon_pkg::ST_CAPT) begin
                    if (inOk && inCmd && r.statusLeft != 2'h0) begin
                        pushEn = 1'b1;
                        n.statusLeft = r.statusLeft - 2'h1;
                    end else if (inOk && !inCmd && r.wordsLeft != 6'h00) begin
                        if (r.modeRx) begin
                            n.modeData = inWord;
                        end else begin
                            pushEn = 1'b1;
                        end
                        n.wordsLeft = r.wordsLeft - 6'h01;
                    end else if (r.wordsLeft == 6'h00 && r.statusLeft == 2'h0) begin
                        // Message complete, drop the notices
                        n.state = mon_pkg::ST_IDLE;
                        n.notify = 1'b0;
                        n.notifyA = 1'b0;
                        n.notifyB = 1'b0;
                        n.flagN = 1'b1;
                    end
                end
            end
            mon_pkg::ST_CMD2: begin
                if (inOk) begin
                    commit = 1'b1;
                    if (decPair) begin
                        n.cmd2 = inWord;
                    end else if (!inCmd) begin
                        pushEn = 1'b1;
                    end
                end
            end
            default: begin
                n.state = mon_pkg::ST_IDLE;
            end
        endcase

        // Type settled: load it and raise the notices
        if (commit) begin
            n.msgType = decMsg;
            n.notify = 1'b1;
            n.notifyA = !n.onB;
            n.notifyB = n.onB;
            n.clrArm = decClr;
            n.clrCnt = mon_pkg::BCAST_CLR_LOAD;
            n.modeRx = decModeRx;
            n.statusLeft = decStat;
            // A data word taken during the pair check counts already
            n.wordsLeft = (r.state == mon_pkg::ST_CMD2 && !decPair && !inCmd)
                ? decCnt - 6'h01 : decCnt;
            n.state = mon_pkg::ST_CAPT;
        end

        // Store: words beyond its depth are dropped
        full = (r.wrPtr - r.rdPtr) == mon_pkg::FIFO_DEPTH;
        pushEn = pushEn && !full;

        // Host read: drive while strobed, pop the store at strobe end
        rdAct = !r.hostS2[6] && !r.hostS2[5] && r.hostS2[4];
        n.rdActPrev = rdAct;
        n.dataOe = rdAct;
        n.dataOut = rdAct ? readMux : mon_pkg::WORD_RESET;
        if (rdAct) begin
            n.rdAddrHeld = r.hostS2[3:0];
        end
        pop = r.rdActPrev && !rdAct && r.rdAddrHeld == mon_pkg::ADDR_RX_FIFO && !r.empty;

        n.wrPtr = r.wrPtr + {5'h00, pushEn};
        n.rdPtr = r.rdPtr + {5'h00, pop};
        n.empty = n.wrPtr == n.rdPtr;
    end

    // State register; reset gives idle, flag high, store empty, mode pin stages at monitor-only
    always_ff @(posedge clk or negedge rstSync) begin
        if (!rstSync) begin
            r <= '0;
            r.flagN <= 1'b1;
            r.empty <= 1'b1;
            {r.modeS1, r.modeS2} <= 4'hF;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign hostDataOut = r.dataOut;
    assign hostDataOe = r.dataOe;
    assign valid_command_notify = r.notify;
    assign bus_a_command_notify = r.notifyA;
    assign bus_b_command_notify = r.notifyB;
    assign capture_flag_n = r.flagN;
    assign rx_fifo_empty = r.empty;
    assign monitor_only_mode = r.monOnly;
    assign busDriveAllow = r.driveAllow;
    assign rtCommandReq = r.rtReq;
endmodule
`default_nettype wire

// ===== test/mon_dec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mon_dec_chk (
    input wire logic clk, // Clock
    input wire logic rst_n, // Reset, low
    input wire logic wordValidA, // A strobe
    input wire logic wordErrA, // A bad word
    input wire logic cmdSyncA, // A command sync
    input wire logic wordValidB, // B strobe
    input wire logic hostDataOe, // Read enable
    input wire logic valid_command_notify, // Notice
    input wire logic bus_a_command_notify, // A notice
    input wire logic bus_b_command_notify, // B notice
    input wire logic capture_flag_n, // Capture flag
    input wire logic rx_fifo_empty, // Store empty
    input wire logic monitor_only_mode, // Monitor only
    input wire logic busDriveAllow // Drive permit
);
    // One clock domain; every check sleeps through reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_flag_with_notify: assert property (valid_command_notify |-> !capture_flag_n)
        else $error("notice while flag high");
    a_notify_one_bus: assert property (valid_command_notify == (bus_a_command_notify ^ bus_b_command_notify))
        else $error("bus notice mismatch");
    a_monitor_no_drive: assert property (monitor_only_mode |-> !busDriveAllow)
        else $error("drive allowed in monitor");
    a_notify_a_cause: assert property ($rose(bus_a_command_notify) |-> $past(wordValidA))
        else $error("bus A notice without A word");
    // A clean command on an idle bus must drop the flag on the next edge
    a_flag_falls_cmd: assert property (wordValidA && !wordErrA && cmdSyncA && !wordValidB
        && monitor_only_mode && capture_flag_n |=> !capture_flag_n)
        else $error("flag missed command");
    a_bad_word_ignored: assert property (wordValidA && wordErrA && !wordValidB && capture_flag_n
        |=> capture_flag_n)
        else $error("bad word captured");
    // Store only fills while a message is being captured
    a_store_in_msg: assert property ($fell(rx_fifo_empty) |-> !capture_flag_n
        || !$past(capture_flag_n) || !$past(capture_flag_n, 2))
        else $error("store filled outside message");
    a_pop_on_read_end: assert property ($rose(rx_fifo_empty) |-> $fell(hostDataOe))
        else $error("empty rose without read end");

    c_bus_b: cover property ($rose(bus_b_command_notify));
    c_bus_a: cover property ($rose(bus_a_command_notify));
    c_drained: cover property ($rose(rx_fifo_empty));
endmodule

bind mil1553_monitor_command_decoder mon_dec_chk u_chk (
    .clk, .rst_n, .wordValidA, .wordErrA, .cmdSyncA, .wordValidB, .hostDataOe,
    .valid_command_notify, .bus_a_command_notify, .bus_b_command_notify,
    .capture_flag_n, .rx_fifo_empty, .monitor_only_mode, .busDriveAllow
);
`default_nettype wire

// ===== test/bus_word_source.sv
`timescale 1ns/1ps
`default_nettype none
// Bus traffic as the word decoder hands it to the block
module bus_word_source (
    input wire logic clk, // Clock
    output logic wordValid, // Word strobe
    output logic [15:0] word, // Word
    output logic cmdSync, // Command or status sync
    output logic wordErr // Word failed checks
);
    initial begin
        wordValid = 1'b0;
        word = 16'h0000;
        cmdSync = 1'b0;
        wordErr = 1'b0;
    end

    // One word per call; gap makes the sender prompt or slow.
    // Lines are inverted after the strobe so stale values never match
    task automatic put(input logic [15:0] w, input logic s, input logic e, input int gap);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        {wordValid, word, cmdSync, wordErr} = {1'b1, w, s, e};
        @(negedge clk);
        {wordValid, word, cmdSync, wordErr} = {1'b0, ~w, ~s, ~e};
    endtask
endmodule
`default_nettype wire

// ===== test/mil1553_monitor_command_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mil1553_monitor_command_decoder_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wordValidA, cmdSyncA, wordErrA, wordValidB, cmdSyncB, wordErrB;
    logic [15:0] wordA, wordB, hostDataOut, v;
    logic terminal_mode_select = 1'b1;
    logic controller_mode_select = 1'b1;
    logic [4:0] own_terminal_address = 5'h03;
    logic hostCs_n = 1'b1;
    logic hostStrobe_n = 1'b1;
    logic hostRead = 1'b1;
    logic [3:0] hostAddr = 4'h0;
    logic hostDataOe, valid_command_notify, bus_a_command_notify, bus_b_command_notify;
    logic capture_flag_n, rx_fifo_empty, monitor_only_mode, busDriveAllow, rtCommandReq;
    logic rtSeen = 1'b0;
    int n_errors = 0;
    int comparisons = 0;

    always #5 clk = ~clk;
    // Own-address request is a pulse, so keep a sticky copy
    always @(posedge clk) if (rtCommandReq === 1'b1) rtSeen <= 1'b1;

    bus_word_source uA (.clk, .wordValid(wordValidA), .word(wordA), .cmdSync(cmdSyncA),
        .wordErr(wordErrA));
    bus_word_source uB (.clk, .wordValid(wordValidB), .word(wordB), .cmdSync(cmdSyncB),
        .wordErr(wordErrB));
    mil1553_monitor_command_decoder uut (.clk, .rst_n, .wordValidA, .wordA, .cmdSyncA,
        .wordErrA, .wordValidB, .wordB, .cmdSyncB, .wordErrB, .terminal_mode_select,
        .controller_mode_select, .own_terminal_address, .hostCs_n, .hostStrobe_n, .hostRead,
        .hostAddr, .hostDataOut, .hostDataOe, .valid_command_notify, .bus_a_command_notify,
        .bus_b_command_notify, .capture_flag_n, .rx_fifo_empty, .monitor_only_mode,
        .busDriveAllow, .rtCommandReq);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Host read: hold select and address until the enable drops, the strobe ends first
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        int k = 0;
        @(negedge clk);
        {hostAddr, hostCs_n, hostStrobe_n} = {a, 2'b00};
        while (hostDataOe !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        d = hostDataOut;
        repeat (5) @(negedge clk);
        hostStrobe_n = 1'b1;
        while (hostDataOe !== 1'b0 && k < 40) begin
            @(negedge clk);
            k++;
        end
        chk(16'(hostDataOe), 16'h0000);
        hostCs_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // Addressed transmit on bus A: notices, registers, store drain
    task automatic t_transmit();
        logic [15:0] st [3] = '{16'h1800, 16'hA5A5, 16'h5A5A};
        uA.put(16'h0C22, 1'b1, 1'b0, 0);
        chk({14'h0, bus_a_command_notify, bus_b_command_notify}, 16'h0002);
        chk(16'(capture_flag_n), 16'h0000);
        uA.put(16'h1800, 1'b1, 1'b0, 3);
        uA.put(16'hA5A5, 1'b0, 1'b0, 0);
        uA.put(16'h5A5A, 1'b0, 1'b0, 0);
        repeat (4) @(negedge clk);
        rd(mon_pkg::ADDR_MSG_TYPE, v);
        chk(v, 16'h0402);
        rd(mon_pkg::ADDR_CMD1, v);
        chk(v, 16'h0C22);
        rd(mon_pkg::ADDR_BUS_A_WORD, v);
        chk(v, 16'h5A5A);
        chk(16'(rx_fifo_empty), 16'h0000);
        for (int i = 0; i < 3; i++) begin
            rd(mon_pkg::ADDR_RX_FIFO, v);
            chk(v, st[i]);
        end
        chk(16'(rx_fifo_empty), 16'h0001);
    endtask

    // Receive and mode command kinds on bus B; follow-word syncs per entry, bit 0 first
    task automatic t_types();
        logic [15:0] cw [9] = '{16'h1821, 16'hF821, 16'h1C02, 16'hFC11, 16'h1801,
            16'hF801, 16'h1C12, 16'hFBF1, 16'h1811};
        logic [15:0] ex [9] = '{16'h0001, 16'h0080, 16'h0410, 16'h0400, 16'h0410,
            16'h0400, 16'h2420, 16'h0800, 16'h0040};
        int nf [9] = '{2, 1, 1, 0, 1, 0, 2, 1, 2};
        logic [1:0] sy [9] = '{2'b10, 2'b00, 2'b01, 2'b00, 2'b01, 2'b00, 2'b01, 2'b00, 2'b10};
        for (int i = 0; i < 9; i++) begin
            uB.put(cw[i], 1'b1, 1'b0, i % 3);
            for (int j = 0; j < nf[i]; j++) uB.put(16'h5A00 + 16'(i * 4 + j), sy[i][j], 1'b0, 0);
            repeat (3) @(negedge clk);
            rd(mon_pkg::ADDR_MSG_TYPE, v);
            chk(v, ex[i]);
            chk(16'(v[5]), 16'(v[13]));
            rd(mon_pkg::ADDR_CMD1, v);
            chk(v, cw[i]);
        end
        rd(mon_pkg::ADDR_MODE_DATA, v);
        chk(v, 16'h5A20);
    endtask

    // Paired transfers, addressed then broadcast
    task automatic t_pairs();
        for (int i = 0; i < 2; i++) begin
            uA.put(i ? 16'hF821 : 16'h1821, 1'b1, 1'b0, 0);
            uA.put(16'h2C21, 1'b1, 1'b0, 2);
            uA.put(16'h2800, 1'b1, 1'b0, 0);
            uA.put(16'h0BAD, 1'b0, 1'b0, 0);
            if (i == 0) uA.put(16'h1800, 1'b1, 1'b0, 0);
            repeat (3) @(negedge clk);
            rd(mon_pkg::ADDR_MSG_TYPE, v);
            chk(v, i ? 16'h0100 : 16'h0004);
            chk(16'(v[2] | v[8]), 16'h0001);
            rd(mon_pkg::ADDR_CMD1, v);
            chk(v, i ? 16'hF821 : 16'h1821);
            rd(mon_pkg::ADDR_CMD2, v);
            chk(v, 16'h2C21);
        end
    endtask

    // Broadcast transmit mode value, then its timed clear
    task automatic t_timed();
        uB.put(16'hFC01, 1'b1, 1'b0, 0);
        rd(mon_pkg::ADDR_MSG_TYPE, v);
        chk(v, 16'h0400);
        repeat (37) @(negedge clk);
        rd(mon_pkg::ADDR_MSG_TYPE, v);
        chk(v, 16'h0400);
        rd(mon_pkg::ADDR_MSG_TYPE, v);
        chk(v, 16'h0000);
    endtask

    // Bad word, unmapped read, then monitor with own address
    task automatic t_modes();
        uA.put(16'h1C02, 1'b1, 1'b1, 0);
        chk(16'(capture_flag_n), 16'h0001);
        chk({14'h0, monitor_only_mode, busDriveAllow}, 16'h0002);
        rd(4'h3, v);
        chk(v, 16'h0000);
        {terminal_mode_select, controller_mode_select} = 2'b00;
        repeat (6) @(negedge clk);
        chk({14'h0, monitor_only_mode, busDriveAllow}, 16'h0001);
        uA.put(16'h1C02, 1'b1, 1'b0, 0);
        uA.put(16'h1800, 1'b1, 1'b0, 0);
        repeat (3) @(negedge clk);
        chk(16'(rtSeen), 16'h0001);
        rd(mon_pkg::ADDR_MSG_TYPE, v);
        chk(v, 16'h0410);
    endtask

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (8) @(negedge clk);
        t_transmit();
        t_types();
        t_pairs();
        t_timed();
        t_modes();
        give_verdict();
    end

    // Whole run needs under a thousand cycles; far beyond that is a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
